// ===== ppfs_pkg.sv
// Behaviour
// RULE1: port mode pin low selects host port, high selects external memory.
// RULE2: reset captures port mode pin as microcomputer mode bit initial value.
// RULE3: each external flag is output only, driven by a software set latch.
// RULE4: off control low floats flags, memory strobe and space selects.
// RULE5: in memory mode general pin 0 is rom enable input after reset.
// RULE6: general io write latches values onto pins configured as outputs.
// RULE7: general io read returns live states of pins configured as inputs.
// RULE8: per pin direction field sets each general pin direction.
// RULE9: general pin 2 as input feeds branch condition, still readable.
// RULE10: program space select asserted for each external program access.
// RULE11: in host mode host drives program select as first host strobe.
// RULE12: data space select asserted for each external data access.
// RULE13: in host mode host drives data select as second host strobe.
// RULE14: io space select asserted for each external io access.
// RULE15: in host mode io select pin becomes sub b general pin 3 and timer.
// RULE16: memory strobe driven only in memory mode, timing accesses; the code strobes program and data accesses only, not io accesses.
// RULE17: read/write output high for reads, low only during writes.
// RULE18: space selects and memory strobe are active low.
// RULE19: pin function changes never glitch an active strobe.
package ppfs_pkg;
  localparam int unsigned GPIO_W     = 4;
  localparam int unsigned GP_ROM_ENABLE_INPUT   = 0;
  localparam int unsigned GP_BRANCH  = 2;
  localparam int unsigned GP_TIMER   = 3;
  localparam logic        FLAG_RST   = 1'b0;
  localparam logic [3:0]  GPIO_RST   = 4'h0;
  localparam logic [3:0]  DIR_RST    = 4'h0;
  localparam logic        STRB_IDLE  = 1'b1;
  localparam logic [1:0]  SPC_PROG   = 2'h0;
  localparam logic [1:0]  SPC_DATA   = 2'h1;
  localparam logic [1:0]  SPC_IO     = 2'h2;

  typedef enum logic [1:0] {
    PPFS_IDLE   = 2'b00,
    PPFS_ACTIVE = 2'b01,
    PPFS_DRAIN  = 2'b11
  } ppfs_acc_t;
endpackage : ppfs_pkg

// ===== ppfs_gpio.sv
`timescale 1ns/1ps
// one subsystem's four general pins, register write/read and direction
module ppfs_gpio (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] wr_val_i,
  input  wire logic [3:0] wr_dir_i,
  input  wire logic [3:0] pin_i,
  output logic      [3:0] pin_o,
  output logic      [3:0] pin_oe_o,
  output logic      [3:0] rd_val_o,
  output logic      [3:0] dir_o,
  output logic            branch_cond_o
);
  logic [3:0] out_r;
  logic [3:0] dir_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_r <= ppfs_pkg::GPIO_RST;
      dir_r <= ppfs_pkg::DIR_RST;
    end else if (wr_i) begin
      out_r <= wr_val_i;  // [RULE6]
      dir_r <= wr_dir_i;  // [RULE8]
    end
  end

  assign pin_o    = out_r;
  assign pin_oe_o = dir_r;  // [RULE8]
  assign dir_o    = dir_r;
  // output pins read back their latch, inputs read the live pin
  assign rd_val_o = (pin_i & ~dir_r) | (out_r & dir_r);  // [RULE7]
  // branch condition only meaningful while pin 2 is an input
  assign branch_cond_o = ~dir_r[ppfs_pkg::GP_BRANCH] &
                         pin_i[ppfs_pkg::GP_BRANCH];  // [RULE9]
endmodule : ppfs_gpio

// ===== ppfs_strobe.sv
`timescale 1ns/1ps
// memory-side strobe sequencer: one access at a time
module ppfs_strobe (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       mem_mode_i,
  input  wire logic       acc_req_i,
  input  wire logic [1:0] acc_space_i,
  input  wire logic       acc_write_i,
  input  wire logic       acc_end_i,
  output logic            prog_sel_n_o,
  output logic            data_sel_n_o,
  output logic            io_sel_n_o,
  output logic            strobe_n_o,
  output logic            rw_o,
  output logic            busy_o
);
  ppfs_pkg::ppfs_acc_t st_r;
  logic [1:0]          space_r;
  logic                wr_r;

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r    <= ppfs_pkg::PPFS_IDLE;
      space_r <= ppfs_pkg::SPC_PROG;
      wr_r    <= 1'b0;
    end else begin
      case (st_r)
        ppfs_pkg::PPFS_IDLE: begin
          // new access only starts in memory mode
          if (acc_req_i && mem_mode_i) begin  // [RULE16]
            st_r    <= ppfs_pkg::PPFS_ACTIVE;
            space_r <= acc_space_i;
            wr_r    <= acc_write_i;
          end
        end
        ppfs_pkg::PPFS_ACTIVE: begin
          // a mode change lets the access finish before release
          if (acc_end_i) begin  // [RULE19]
            st_r <= ppfs_pkg::PPFS_DRAIN;
          end
        end
        ppfs_pkg::PPFS_DRAIN: begin
          st_r <= ppfs_pkg::PPFS_IDLE;
          wr_r <= 1'b0;
        end
        default: begin
          st_r <= ppfs_pkg::PPFS_IDLE;
        end
      endcase
    end
  end

  logic act;
  assign act = (st_r == ppfs_pkg::PPFS_ACTIVE);

  // ---------------------------------------------------------------
  // registered active-low strobes, glitch free
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prog_sel_n_o <= ppfs_pkg::STRB_IDLE;
      data_sel_n_o <= ppfs_pkg::STRB_IDLE;
      io_sel_n_o   <= ppfs_pkg::STRB_IDLE;
      strobe_n_o   <= ppfs_pkg::STRB_IDLE;
      rw_o         <= 1'b1;
    end else begin
      prog_sel_n_o <= ~(act & (space_r == ppfs_pkg::SPC_PROG));  // [RULE10] [RULE18]
      data_sel_n_o <= ~(act & (space_r == ppfs_pkg::SPC_DATA));  // [RULE12] [RULE18]
      io_sel_n_o   <= ~(act & (space_r == ppfs_pkg::SPC_IO));    // [RULE14] [RULE18]
      strobe_n_o   <= ~(act & (space_r == ppfs_pkg::SPC_PROG ||
                               space_r == ppfs_pkg::SPC_DATA));  // [RULE16]
      rw_o         <= ~(act & wr_r);  // [RULE17]
    end
  end

  assign busy_o = (st_r != ppfs_pkg::PPFS_IDLE);
endmodule : ppfs_strobe

// ===== ppfs_top.sv
`timescale 1ns/1ps
module ppfs_top (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       port_mode_pin_i,
  input  wire logic       off_n_i,
  // external flags, one per subsystem
  input  wire logic       flag_a_set_i,
  input  wire logic       flag_a_clr_i,
  input  wire logic       flag_b_set_i,
  input  wire logic       flag_b_clr_i,
  output logic            flag_a_o,
  output logic            flag_a_oe_o,
  output logic            flag_b_o,
  output logic            flag_b_oe_o,
  // mode status
  output logic            host_port_mode_o,
  output logic            microcomputer_mode_bit_o,
  output logic            rom_enable_a_o,
  output logic            rom_enable_b_o,
  // general io register access per subsystem
  input  wire logic       gpio_a_wr_i,
  input  wire logic [3:0] gpio_a_wr_val_i,
  input  wire logic [3:0] gpio_a_wr_dir_i,
  output logic      [3:0] gpio_a_rd_val_o,
  output logic      [3:0] gpio_a_dir_o,
  input  wire logic       gpio_b_wr_i,
  input  wire logic [3:0] gpio_b_wr_val_i,
  input  wire logic [3:0] gpio_b_wr_dir_i,
  output logic      [3:0] gpio_b_rd_val_o,
  output logic      [3:0] gpio_b_dir_o,
  input  wire logic       timer_output_sub_b_i,
  output logic            branch_cond_a_o,
  output logic            branch_cond_b_o,
  // general io pins
  input  wire logic [3:0] gpio_a_pin_i,
  output logic      [3:0] gpio_a_pin_o,
  output logic      [3:0] gpio_a_pin_oe_o,
  input  wire logic [2:0] gpio_b_pin_i,
  output logic      [2:0] gpio_b_pin_o,
  output logic      [2:0] gpio_b_pin_oe_o,
  // external access requests from the core
  input  wire logic       acc_req_i,
  input  wire logic [1:0] acc_space_i,
  input  wire logic       acc_write_i,
  input  wire logic       acc_end_i,
  output logic            acc_busy_o,
  // shared memory control pins
  input  wire logic       prog_sel_pin_i,
  output logic            prog_sel_n_o,
  output logic            prog_sel_oe_o,
  input  wire logic       data_sel_pin_i,
  output logic            data_sel_n_o,
  output logic            data_sel_oe_o,
  input  wire logic       io_sel_pin_i,
  output logic            io_sel_o,
  output logic            io_sel_oe_o,
  output logic            memory_strobe_n_o,
  output logic            memory_strobe_oe_o,
  output logic            rw_o,
  output logic            rw_oe_o,
  output logic            host_strobe_one_n_o,
  output logic            host_strobe_two_n_o
);
  // ---------------------------------------------------------------
  // mode and reset capture
  // ---------------------------------------------------------------
  logic mode_r;
  logic seen_r;
  logic mpmc_r;
  logic roma_r;
  logic romb_r;
  logic busy;

  // mode follows pin, but waits while an access is open or being taken,
  // else the pins would swap function under a starting strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r <= 1'b0;
    end else if (!busy && !(acc_req_i && mode_r)) begin
      mode_r <= port_mode_pin_i;  // [RULE1] [RULE19]
    end
  end

  // straps are caught on the first edge after reset release
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_r <= 1'b0;
      mpmc_r <= 1'b0;
      roma_r <= 1'b0;
      romb_r <= 1'b0;
    end else if (!seen_r) begin
      seen_r <= 1'b1;
      mpmc_r <= port_mode_pin_i;  // [RULE2]
      roma_r <= port_mode_pin_i & gpio_a_pin_i[ppfs_pkg::GP_ROM_ENABLE_INPUT];  // [RULE5]
      romb_r <= port_mode_pin_i & gpio_b_pin_i[ppfs_pkg::GP_ROM_ENABLE_INPUT];  // [RULE5]
    end
  end

  assign host_port_mode_o         = ~mode_r;
  assign microcomputer_mode_bit_o = mpmc_r;
  assign rom_enable_a_o           = roma_r;
  assign rom_enable_b_o           = romb_r;

  // ---------------------------------------------------------------
  // external flags
  // ---------------------------------------------------------------
  logic fla_r;
  logic flb_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fla_r <= ppfs_pkg::FLAG_RST;
      flb_r <= ppfs_pkg::FLAG_RST;
    end else begin
      if (flag_a_set_i) fla_r <= 1'b1;  // [RULE3]
      else if (flag_a_clr_i) fla_r <= 1'b0;
      if (flag_b_set_i) flb_r <= 1'b1;  // [RULE3]
      else if (flag_b_clr_i) flb_r <= 1'b0;
    end
  end

  assign flag_a_o    = fla_r;
  assign flag_b_o    = flb_r;
  assign flag_a_oe_o = off_n_i;  // [RULE4]
  assign flag_b_oe_o = off_n_i;  // [RULE4]

  // ---------------------------------------------------------------
  // general io
  // ---------------------------------------------------------------
  logic [3:0] a_po;
  logic [3:0] a_oe;
  logic [3:0] b_po;
  logic [3:0] b_oe;
  logic [3:0] b_pin;

  // sub b pin 3 lives on the io select pin in host mode
  assign b_pin = {io_sel_pin_i, gpio_b_pin_i};  // [RULE15]

  ppfs_gpio u_gpio_a (
    .ref_clk_i     (ref_clk_i),
    .arst_n_i      (arst_n_i),
    .wr_i          (gpio_a_wr_i),
    .wr_val_i      (gpio_a_wr_val_i),
    .wr_dir_i      (gpio_a_wr_dir_i),
    .pin_i         (gpio_a_pin_i),
    .pin_o         (a_po),
    .pin_oe_o      (a_oe),
    .rd_val_o      (gpio_a_rd_val_o),
    .dir_o         (gpio_a_dir_o),
    .branch_cond_o (branch_cond_a_o)
  );

  ppfs_gpio u_gpio_b (
    .ref_clk_i     (ref_clk_i),
    .arst_n_i      (arst_n_i),
    .wr_i          (gpio_b_wr_i),
    .wr_val_i      (gpio_b_wr_val_i),
    .wr_dir_i      (gpio_b_wr_dir_i),
    .pin_i         (b_pin),
    .pin_o         (b_po),
    .pin_oe_o      (b_oe),
    .rd_val_o      (gpio_b_rd_val_o),
    .dir_o         (gpio_b_dir_o),
    .branch_cond_o (branch_cond_b_o)
  );

  // in memory mode pin 0 is held as the rom enable input
  assign gpio_a_pin_o    = a_po;
  assign gpio_a_pin_oe_o = a_oe & {3'h7, ~mode_r};  // [RULE5]
  assign gpio_b_pin_o    = b_po[2:0];
  assign gpio_b_pin_oe_o = b_oe[2:0] & {2'h3, ~mode_r};  // [RULE5]

  // ---------------------------------------------------------------
  // memory strobes and pin sharing
  // ---------------------------------------------------------------
  logic ps_n;
  logic ds_n;
  logic is_n;
  logic ms_n;
  logic rw;

  ppfs_strobe u_strobe (
    .ref_clk_i    (ref_clk_i),
    .arst_n_i     (arst_n_i),
    .mem_mode_i   (mode_r),
    .acc_req_i    (acc_req_i),
    .acc_space_i  (acc_space_i),
    .acc_write_i  (acc_write_i),
    .acc_end_i    (acc_end_i),
    .prog_sel_n_o (ps_n),
    .data_sel_n_o (ds_n),
    .io_sel_n_o   (is_n),
    .strobe_n_o   (ms_n),
    .rw_o         (rw),
    .busy_o       (busy)
  );

  assign acc_busy_o        = busy;
  assign prog_sel_n_o      = ps_n;
  assign data_sel_n_o      = ds_n;
  assign memory_strobe_n_o = ms_n;
  assign rw_o              = rw;

  // host mode: select pins are host strobe inputs, never driven
  assign prog_sel_oe_o       = off_n_i & mode_r;  // [RULE4] [RULE11]
  assign data_sel_oe_o       = off_n_i & mode_r;  // [RULE4] [RULE13]
  assign memory_strobe_oe_o  = off_n_i & mode_r;  // [RULE4] [RULE16]
  assign rw_oe_o             = off_n_i & mode_r;  // [RULE17]
  assign host_strobe_one_n_o = prog_sel_pin_i;  // [RULE11]
  assign host_strobe_two_n_o = data_sel_pin_i;  // [RULE13]

  // io select pin: space select in memory mode, sub b pin 3 otherwise
  logic b3_val;
  assign b3_val = b_po[ppfs_pkg::GP_TIMER] | timer_output_sub_b_i;
  assign io_sel_o    = mode_r ? is_n : b3_val;  // [RULE15]
  assign io_sel_oe_o = off_n_i &
                       (mode_r | b_oe[ppfs_pkg::GP_TIMER]);  // [RULE4] [RULE15]
endmodule : ppfs_top

// ===== ppfs_checker.sv
`timescale 1ns/1ps
module ppfs_checker (
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic       off_n_i,
  input wire logic       flag_a_oe_o,
  input wire logic       flag_b_oe_o,
  input wire logic       host_port_mode_o,
  input wire logic       acc_req_i,
  input wire logic       acc_write_i,
  input wire logic       acc_end_i,
  input wire logic       acc_busy_o,
  input wire logic       prog_sel_n_o,
  input wire logic       prog_sel_oe_o,
  input wire logic       data_sel_n_o,
  input wire logic       data_sel_oe_o,
  input wire logic       io_sel_o,
  input wire logic       memory_strobe_n_o,
  input wire logic       memory_strobe_oe_o,
  input wire logic       rw_o,
  input wire logic       prog_sel_pin_i,
  input wire logic       data_sel_pin_i,
  input wire logic       host_strobe_one_n_o,
  input wire logic       host_strobe_two_n_o,
  input wire logic [3:0] gpio_a_dir_o,
  input wire logic [3:0] gpio_a_pin_i,
  input wire logic       branch_cond_a_o
);
  logic act;
  logic take;
  assign act = !prog_sel_n_o || !data_sel_n_o ||
               (!io_sel_o && !host_port_mode_o);
  assign take = acc_req_i && !acc_busy_o && !host_port_mode_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  req_select_a: assert property (take |-> ##2 act)
    else $error("no select two cycles after request");
  write_dir_a: assert property (take && acc_write_i |-> ##2 !rw_o)
    else $error("write access left rw high");
  rw_idle_a: assert property (!rw_o |-> act)
    else $error("rw low outside an access");
  end_release_a: assert property (acc_end_i && act |-> ##2 (!act && rw_o))
    else $error("selects not released after end");
  strobe_space_a: assert property (!memory_strobe_n_o |->
    !prog_sel_n_o || !data_sel_n_o)
    else $error("memory strobe without program or data select");
  float_all_a: assert property (!off_n_i |-> !(flag_a_oe_o || flag_b_oe_o
    || memory_strobe_oe_o || prog_sel_oe_o || data_sel_oe_o))
    else $error("output driven while off control low");
  host_nostrb_a: assert property (host_port_mode_o |-> !memory_strobe_oe_o)
    else $error("memory strobe driven in host mode");
  host_refuse_a: assert property (acc_req_i && host_port_mode_o
    && !acc_busy_o |=> !acc_busy_o)
    else $error("access taken in host mode");
  host_strobe_a: assert property (host_port_mode_o |->
    host_strobe_one_n_o == prog_sel_pin_i &&
    host_strobe_two_n_o == data_sel_pin_i)
    else $error("host strobe not passed through");
  branch_src_a: assert property (branch_cond_a_o ==
    (!gpio_a_dir_o[2] && gpio_a_pin_i[2]))
    else $error("branch condition not from pin 2");
endmodule : ppfs_checker

bind ppfs_top ppfs_checker ppfs_checker_inst (.*);

// ===== ppfs_mem_model.sv
`timescale 1ns/1ps
module ppfs_mem_model (
  input  wire logic       ref_clk_i,
  input  wire logic       act_i,
  input  wire logic       host_i,
  input  wire logic [3:0] wait_i,
  input  wire logic [1:0] host_strb_i,
  output logic            end_o,
  output logic            ps_pin_o,
  output logic            ds_pin_o
);
  int cnt = 0;
  bit done = 1'b0;
  initial end_o = 1'b0;
  // pulled up while no host drives them
  assign ps_pin_o = host_i ? host_strb_i[0] : 1'b1;
  assign ds_pin_o = host_i ? host_strb_i[1] : 1'b1;
  // one end pulse per access, after wait_i cycles of select
  always @(posedge ref_clk_i) begin
    end_o <= #1 1'b0;
    if (!act_i) begin
      done = 1'b0;
      cnt = 0;
    end else if (!done) begin
      if (cnt >= int'(wait_i)) begin
        end_o <= #1 1'b1;
        done = 1'b1;
      end else cnt++;
    end
  end
endmodule : ppfs_mem_model

// ===== ppfs_tb_top.sv
`timescale 1ns/1ps
module ppfs_tb_top;
  logic ref_clk_i, arst_n_i, port_mode_pin_i, off_n_i, timer_output_sub_b_i;
  logic flag_a_set_i, flag_a_clr_i, flag_b_set_i, flag_b_clr_i;
  logic gpio_a_wr_i, gpio_b_wr_i, acc_req_i, acc_write_i, acc_end_i;
  logic prog_sel_pin_i, data_sel_pin_i, io_sel_pin_i, act;
  logic [3:0] gpio_a_wr_val_i, gpio_a_wr_dir_i, gpio_b_wr_val_i;
  logic [3:0] gpio_b_wr_dir_i, gpio_a_pin_i, wait_n;
  logic [2:0] gpio_b_pin_i, gpio_b_pin_o, gpio_b_pin_oe_o;
  logic [1:0] acc_space_i, hs;
  logic flag_a_o, flag_a_oe_o, flag_b_o, flag_b_oe_o, host_port_mode_o;
  logic microcomputer_mode_bit_o, rom_enable_a_o, rom_enable_b_o;
  logic branch_cond_a_o, branch_cond_b_o, acc_busy_o, prog_sel_n_o;
  logic prog_sel_oe_o, data_sel_n_o, data_sel_oe_o, io_sel_o, io_sel_oe_o;
  logic memory_strobe_n_o, memory_strobe_oe_o, rw_o, rw_oe_o;
  logic host_strobe_one_n_o, host_strobe_two_n_o;
  logic [3:0] gpio_a_rd_val_o, gpio_a_dir_o, gpio_b_rd_val_o, gpio_b_dir_o;
  logic [3:0] gpio_a_pin_o, gpio_a_pin_oe_o, ea, eb;
  logic [31:0] r;
  int failures = 0;
  int n_compared = 0;
  assign act = !prog_sel_n_o || !data_sel_n_o ||
               (!io_sel_o && !host_port_mode_o);
  ppfs_top ppfs_top_inst (.*);
  ppfs_mem_model ppfs_mem_model_inst (.ref_clk_i, .act_i(act),
    .host_i(host_port_mode_o), .wait_i(wait_n), .host_strb_i(hs),
    .end_o(acc_end_i), .ps_pin_o(prog_sel_pin_i), .ds_pin_o(data_sel_pin_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // one access; a second request while busy must be dropped
  task automatic access(input int sp, input int wr, input int w);
    int k;
    wait_n = w[3:0];
    acc_space_i = sp[1:0];
    acc_write_i = wr[0];
    acc_req_i = 1'b1;
    cyc(1);
    acc_req_i = 1'b0;
    k = 0;
    while (!act && k < 20) begin cyc(1); k++; end
    chk("psel", sp != 0, prog_sel_n_o);
    chk("dsel", sp != 1, data_sel_n_o);
    chk("isel", sp != 2, io_sel_o);
    chk("strb", sp == 2, memory_strobe_n_o);
    chk("rw", wr == 0, rw_o);
    chk("oeon", 4'hf, {prog_sel_oe_o, data_sel_oe_o, rw_oe_o,
        memory_strobe_oe_o & io_sel_oe_o});
    acc_req_i = 1'b1;
    cyc(1);
    acc_req_i = 0;
    k = 0;
    while (acc_busy_o && k < 30) begin cyc(1); k++; end
    chk("idle", 4'h7, {1'b0, prog_sel_n_o, data_sel_n_o,
        memory_strobe_n_o});
    cyc(2);
    chk("drop", 4'h0, act);
  endtask : access
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {flag_a_set_i, flag_a_clr_i, flag_b_set_i, flag_b_clr_i} = 4'h0;
    {gpio_a_wr_i, gpio_b_wr_i, acc_req_i, acc_write_i} = 4'h0;
    {gpio_a_wr_val_i, gpio_a_wr_dir_i, gpio_b_wr_val_i} = 12'h000;
    {gpio_b_wr_dir_i, gpio_b_pin_i, acc_space_i, hs} = 11'h003;
    {timer_output_sub_b_i, io_sel_pin_i, wait_n} = 6'h00;
    gpio_a_pin_i = 4'h1;
    port_mode_pin_i = 1'b1;
    off_n_i = 1'b1;
    arst_n_i = 1'b0;
    r = $urandom(32'h6c2e0423);
    repeat (5) @(posedge ref_clk_i);
    #1 arst_n_i = 1'b1;
    cyc(2);
    chk("mcbit", 4'h1, microcomputer_mode_bit_o);
    chk("hmode", 4'h0, host_port_mode_o);
    chk("rom", 4'h2, {rom_enable_a_o, rom_enable_b_o});
    $display("test strap done");
    flag_a_set_i = 1'b1;
    flag_b_set_i = 1'b1;
    flag_b_clr_i = 1'b1;
    cyc(1);
    chk("flag", 4'h3, {flag_a_o, flag_b_o});
    {flag_a_set_i, flag_b_set_i, flag_a_clr_i, flag_b_clr_i} = 4'h2;
    cyc(1);
    chk("flag", 4'h1, {flag_a_o, flag_b_o});
    off_n_i = 1'b0;
    #1 chk("oe", 4'h0, {flag_a_oe_o, flag_b_oe_o, io_sel_oe_o,
        memory_strobe_oe_o});
    chk("oe2", 4'h0, {1'b0, prog_sel_oe_o, data_sel_oe_o, rw_oe_o});
    cyc(1);
    {off_n_i, flag_b_clr_i} = 2'h2;
    $display("test flags done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      {gpio_a_wr_val_i, gpio_a_wr_dir_i, gpio_a_pin_i} = r[11:0];
      {gpio_b_wr_val_i, gpio_b_wr_dir_i, gpio_b_pin_i} = r[22:12];
      io_sel_pin_i = r[23];
      {gpio_a_wr_i, gpio_b_wr_i} = 2'h3;
      cyc(1);
      {gpio_a_wr_i, gpio_b_wr_i} = 2'h0;
      ea = (r[7:4] & r[11:8]) | (~r[7:4] & r[3:0]);
      eb = (r[18:15] & r[22:19]) | (~r[18:15] & {r[23], r[14:12]});
      chk("rda", ea, gpio_a_rd_val_o);
      chk("rdb", eb, gpio_b_rd_val_o);
      chk("dirb", r[18:15], gpio_b_dir_o);
      chk("oeb", {1'b0, r[17:15] & 3'h6}, {1'b0, gpio_b_pin_oe_o});
      chk("dira", r[7:4], gpio_a_dir_o);
      chk("oea", r[7:4] & 4'he, gpio_a_pin_oe_o);
      chk("pina", r[7:4] & r[11:8] & 4'he,
          gpio_a_pin_o & gpio_a_pin_oe_o);
      ea = {1'b0, r[21:19] & r[17:15] & 3'h6};
      chk("pinb", ea, {1'b0, gpio_b_pin_o & gpio_b_pin_oe_o});
      chk("bra", !r[6] && r[2], branch_cond_a_o);
      chk("brb", !r[17] && r[14], branch_cond_b_o);
    end
    $display("test gpio done");
    for (int sp = 0; sp < 3; sp++)
      for (int wr = 0; wr < 2; wr++) access(sp, wr, (2 * sp + wr) % 4);
    $display("test access done");
    wait_n = 4'h4;
    {acc_req_i, acc_space_i, acc_write_i} = 4'h8;
    cyc(1);
    acc_req_i = 1'b0;
    cyc(1);
    port_mode_pin_i = 1'b0;
    cyc(2);
    chk("hold", 4'h0, {host_port_mode_o, prog_sel_n_o});
    cyc(8);
    chk("hmode", 4'h1, host_port_mode_o);
    $display("test switch done");
    hs = 2'h1;
    cyc(1);
    chk("hstr", 4'h2, {host_strobe_one_n_o, host_strobe_two_n_o});
    chk("mso", 4'h0, memory_strobe_oe_o);
    {gpio_b_wr_dir_i, gpio_b_wr_val_i, gpio_b_wr_i} = 9'h101;
    timer_output_sub_b_i = 1'b1;
    cyc(1);
    gpio_b_wr_i = 1'b0;
    cyc(1);
    chk("tout", 4'h3, {io_sel_o, io_sel_oe_o});
    timer_output_sub_b_i = 1'b0;
    cyc(2);
    chk("tout", 4'h1, {io_sel_o, io_sel_oe_o});
    acc_req_i = 1'b1;
    cyc(1);
    acc_req_i = 1'b0;
    cyc(3);
    chk("rfs", 4'h0, {acc_busy_o, act});
    $display("test host done");
    tally_and_finish();
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : ppfs_tb_top
